// ==== core/phy_fall_event_enable.sv ====
//
// Contract
// - Bit 4 enables ident-ground fall events.
// - Ident fall masked: pull-up off, 50 ms after.
// - Bit 3 enables session-end fall events.
// - Bit 2 enables session-valid fall events.
// - Bit 1 enables bus-power-valid fall events.
// - Bit 0: host-disconnect fall, host mode only.
// - Main enable register at 0x10, read-write.
// - Writing ones at 0x11 sets bits.
// - Writing ones at 0x12 clears bits.
// - Aliases read the main register, no storage.
// - Enabled fall sets the interrupt latch bit.
//
`include "fall_event_defines.svh"
`default_nettype none

module phy_fall_event_enable
  import fall_event_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = 32'(`FEE_SETTLE_CYCLES)
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  // Register-access port from the link-side command decoder.
  input  wire logic [`FEE_ADDR_W-1:0] reg_addr,
  input  wire logic                   reg_wr_en,
  input  wire logic [`FEE_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_rd_en,
  output logic      [`FEE_DATA_W-1:0] reg_rdata,
  output logic                        reg_rd_hit,
  // Live status signals.
  input  wire logic                   ident_grounded,
  input  wire logic                   session_end_status,
  input  wire logic                   session_valid_status,
  input  wire logic                   bus_power_valid,
  input  wire logic                   host_disconnect_status,
  // Control bits held elsewhere in the register set.
  input  wire logic                   ident_pull_resistor_en,
  input  wire logic                   plus_line_pull_down_en,
  input  wire logic                   minus_line_pull_down_en,
  // Latch-set pulses and a copy of the enables.
  output fall_mask_t                  fall_latch_set,
  output fall_mask_t                  fall_enable
);

  // --------------------------------------------------------------------------
  // Internal signals
  // --------------------------------------------------------------------------
  fall_event_if  evt ();
  fall_mask_t    status_vec;
  fall_mask_t    enable_q;
  fall_mask_t    enable_d;
  fall_mask_t    wr_bits;
  fall_mask_t    gate;
  fall_mask_t    latch_set_q;
  reg_view_t     wr_view;
  reg_view_t     rd_view;
  logic [`FEE_DATA_W-1:0] rdata_q;
  logic          rd_hit_q;
  logic          host_mode;

  // Gather status inputs into the register's bit order.
  always_comb begin
    status_vec                     = '0;
    status_vec[`FEE_BIT_IDENT_GND] = ident_grounded;
    status_vec[`FEE_BIT_SESS_END]  = session_end_status;
    status_vec[`FEE_BIT_SESS_OK]   = session_valid_status;
    status_vec[`FEE_BIT_BUS_POWER] = bus_power_valid;
    status_vec[`FEE_BIT_HOST_DISC] = host_disconnect_status;
  end

  // --------------------------------------------------------------------------
  // Edge detection and ident settling
  // --------------------------------------------------------------------------
  // previous-cycle compare
  fall_edge_detect #(
    .WIDTH (`FEE_FIELD_W)
  ) u_detect (
    .core_clk (core_clk),
    .reset    (reset),
    .status   (status_vec),
    .evt      (evt.detect)
  );

  ident_settle_timer #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .core_clk   (core_clk),
    .reset      (reset),
    .pull_up_en (ident_pull_resistor_en),
    .tmr        (evt.timer)
  );

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  // Decode one view per access. Addresses outside the three views give
  // ACC_NONE and are left for other register blocks to answer.
  function automatic reg_view_t decode_view(input logic [`FEE_ADDR_W-1:0] a);
    reg_view_t v;
    v = ACC_NONE;
    if (a == `FEE_OFS_MAIN) begin
      v = ACC_MAIN;
    end else if (a == `FEE_OFS_SET) begin
      v = ACC_SET;
    end else if (a == `FEE_OFS_CLEAR) begin
      v = ACC_CLEAR;
    end
    return v;
  endfunction : decode_view

  assign wr_view = reg_wr_en ? decode_view(reg_addr) : ACC_NONE;
  assign rd_view = reg_rd_en ? decode_view(reg_addr) : ACC_NONE;
  // Bits 7 to 5 of write data are dropped: they have no storage.
  assign wr_bits = reg_wdata[`FEE_FIELD_W-1:0];

  // --------------------------------------------------------------------------
  // Enable register next value
  // --------------------------------------------------------------------------
  always_comb begin
    enable_d = enable_q;
    unique case (wr_view)
      ACC_NONE: begin
        enable_d = enable_q;
      end
      ACC_MAIN: begin
        enable_d = wr_bits;
      end
      ACC_SET: begin
        enable_d = enable_q | wr_bits;
      end
      ACC_CLEAR: begin
        enable_d = enable_q & ~wr_bits;
      end
    endcase
  end

  // One physical register; the aliases only change how writes combine.
  // reset all enabled
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      enable_q <= `FEE_RESET_VALUE;
    end else begin
      enable_q <= enable_d;
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Read data is registered, so it appears one cycle after the request.
  // aliases read main
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_q  <= '0;
      rd_hit_q <= 1'b0;
    end else begin
      rd_hit_q <= (rd_view != ACC_NONE);
      if (rd_view != ACC_NONE) begin
        rdata_q <= {{(`FEE_DATA_W - `FEE_FIELD_W){1'b0}}, enable_q};
      end else begin
        rdata_q <= '0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Event qualification
  // --------------------------------------------------------------------------
  // Host disconnect only means something with both data-line pull-downs on.
  assign host_mode = plus_line_pull_down_en & minus_line_pull_down_en;

  always_comb begin
    gate = '1;
    gate[`FEE_BIT_IDENT_GND] = evt.ident_settled;
    gate[`FEE_BIT_HOST_DISC] = host_mode;
  end

  // A fall is judged against the enables held before any same-cycle write,
  // so a write never races an edge already in flight.
  // latch set pulse
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      latch_set_q <= '0;
    end else begin
      latch_set_q <= evt.status_fall & enable_q & gate;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign reg_rdata      = rdata_q;
  assign reg_rd_hit     = rd_hit_q;
  assign fall_latch_set = latch_set_q;
  assign fall_enable    = enable_q;

endmodule : phy_fall_event_enable

`default_nettype wire

// ==== core/fall_event_defines.svh ====
`ifndef FALL_EVENT_DEFINES_SVH
`define FALL_EVENT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets on the register-access port
// ----------------------------------------------------------------------------
`define FEE_ADDR_W        6
`define FEE_OFS_MAIN      6'h10
`define FEE_OFS_SET       6'h11
`define FEE_OFS_CLEAR     6'h12

// ----------------------------------------------------------------------------
// Field layout and reset value
// ----------------------------------------------------------------------------
`define FEE_DATA_W        8
`define FEE_FIELD_W       5
`define FEE_BIT_HOST_DISC 0
`define FEE_BIT_BUS_POWER 1
`define FEE_BIT_SESS_OK   2
`define FEE_BIT_SESS_END  3
`define FEE_BIT_IDENT_GND 4
`define FEE_RESET_VALUE   5'h1f

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FEE_CLK_HZ        64'd40000000
`define FEE_SETTLE_MS     64'd50
// Shortest-time mask, so the count is rounded down by the division.
`define FEE_SETTLE_CYCLES ((`FEE_SETTLE_MS * `FEE_CLK_HZ) / 64'd1000)

`endif

// ==== core/fall_event_pkg.sv ====
`default_nettype none

package fall_event_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  // One bit per watched status signal.
  typedef logic [4:0] fall_mask_t;

  // Which of the three register views an access targets.
  typedef enum logic [1:0] {
    ACC_NONE  = 2'b00,
    ACC_MAIN  = 2'b01,
    ACC_SET   = 2'b10,
    ACC_CLEAR = 2'b11
  } reg_view_t;

endpackage : fall_event_pkg

`default_nettype wire

// ==== core/fall_event_if.sv ====
`default_nettype none

interface fall_event_if;
  import fall_event_pkg::*;

  fall_mask_t status_fall;   // One-cycle falling-edge flags.
  logic       ident_settled; // Ident pull-up on and settled.

  modport detect (output status_fall);
  modport timer  (output ident_settled);
  modport core   (input status_fall, input ident_settled);
endinterface : fall_event_if

`default_nettype wire

// ==== core/fall_edge_detect.sv ====
`include "fall_event_defines.svh"
`default_nettype none

module fall_edge_detect
  import fall_event_pkg::*;
#(
  parameter int WIDTH = `FEE_FIELD_W
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] status,
  fall_event_if.detect          evt
);

  logic [WIDTH-1:0] prev_q;

  // --------------------------------------------------------------------------
  // Per-signal edge detection
  // --------------------------------------------------------------------------
  // Status inputs are already synchronous, so one history flop per bit
  // suffices. Reset holds history low so no fall is reported after release.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        prev_q[i] <= 1'b0;
      end else begin
        prev_q[i] <= status[i];
      end
    end
    assign evt.status_fall[i] = prev_q[i] & ~status[i];
  end

endmodule : fall_edge_detect

`default_nettype wire

// ==== core/ident_settle_timer.sv ====
`include "fall_event_defines.svh"
`default_nettype none

module ident_settle_timer #(
  parameter int unsigned SETTLE_CYCLES = 32'(`FEE_SETTLE_CYCLES)
) (
  input  wire logic    core_clk,
  input  wire logic    reset,
  input  wire logic    pull_up_en,
  fall_event_if.timer  tmr
);

  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

  logic [CNT_W-1:0] count_q;
  logic             settled_q;

  // --------------------------------------------------------------------------
  // Settling counter
  // --------------------------------------------------------------------------
  // Dropping the pull-up restarts the wait, so every new 0-to-1 write of the
  // enable buys a fresh full interval before ident edges are trusted.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_q   <= '0;
      settled_q <= 1'b0;
    end else if (!pull_up_en) begin
      count_q   <= '0;
      settled_q <= 1'b0;
    end else if (count_q == CNT_W'(SETTLE_CYCLES)) begin
      settled_q <= 1'b1;
    end else begin
      count_q <= count_q + CNT_W'(1);
    end
  end

  assign tmr.ident_settled = settled_q;

endmodule : ident_settle_timer

`default_nettype wire

// ==== verification/phy_fall_event_enable_asserts.sv ====
`include "fall_event_defines.svh"
`default_nettype none

module phy_fall_event_enable_asserts
  import fall_event_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = 8
) (
  input wire logic                   core_clk,
  input wire logic                   reset,
  input wire logic [`FEE_ADDR_W-1:0] reg_addr,
  input wire logic                   reg_wr_en,
  input wire logic [`FEE_DATA_W-1:0] reg_wdata,
  input wire logic                   reg_rd_en,
  input wire logic [`FEE_DATA_W-1:0] reg_rdata,
  input wire logic                   reg_rd_hit,
  input wire logic                   ident_grounded,
  input wire logic                   session_end_status,
  input wire logic                   session_valid_status,
  input wire logic                   bus_power_valid,
  input wire logic                   host_disconnect_status,
  input wire logic                   ident_pull_resistor_en,
  input wire logic                   plus_line_pull_down_en,
  input wire logic                   minus_line_pull_down_en,
  input wire fall_mask_t             fall_latch_set,
  input wire fall_mask_t             fall_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  logic        hit;
  int unsigned pu_cnt_q;
  // Any of the three register views answers.
  assign hit = reg_addr inside {`FEE_OFS_MAIN, `FEE_OFS_SET, `FEE_OFS_CLEAR};

  // Pull-up on-time, saturated so it cannot wrap during long runs.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pu_cnt_q <= 0;
    end else if (!ident_pull_resistor_en) begin
      pu_cnt_q <= 0;
    end else if (pu_cnt_q < 1000) begin
      pu_cnt_q <= pu_cnt_q + 1;
    end
  end

  a_read_hit: assert property (reg_rd_en && hit |=> reg_rd_hit && reg_rdata == {3'h0, $past(fall_enable)})
    else $error("read of enable view wrong");
  a_miss_quiet: assert property (reg_rd_en && !hit |=> !reg_rd_hit && reg_rdata == 8'h00)
    else $error("unmapped read answered");
  a_main_write: assert property (reg_wr_en && reg_addr == `FEE_OFS_MAIN |=> fall_enable == $past(reg_wdata[4:0]))
    else $error("main write not stored");
  a_set_alias: assert property (reg_wr_en && reg_addr == `FEE_OFS_SET
    |=> fall_enable == ($past(fall_enable) | $past(reg_wdata[4:0]))) else $error("set view wrong");
  a_clear_alias: assert property (reg_wr_en && reg_addr == `FEE_OFS_CLEAR
    |=> fall_enable == ($past(fall_enable) & ~$past(reg_wdata[4:0]))) else $error("clear view wrong");
  a_enable_hold: assert property (!(reg_wr_en && hit) |=> $stable(fall_enable))
    else $error("enables changed without write");
  a_bus_fall: assert property (!$past(reset) && $past(bus_power_valid) && !bus_power_valid
    |=> fall_latch_set[1] == $past(fall_enable[1])) else $error("bus power fall wrong");
  a_sess_fall: assert property (!$past(reset) && $past(session_end_status) && !session_end_status
    |=> fall_latch_set[3] == $past(fall_enable[3])) else $error("session end fall wrong");
  a_host_gate: assert property (fall_latch_set[0] |-> $past(plus_line_pull_down_en && minus_line_pull_down_en))
    else $error("disconnect fall outside host mode");
  a_ident_mask: assert property (fall_latch_set[4] |-> $past(pu_cnt_q) >= SETTLE_CYCLES + 1)
    else $error("ident fall not masked");
  a_no_spurious: assert property (fall_latch_set[1] |-> $past(bus_power_valid, 2) && !$past(bus_power_valid))
    else $error("bus power pulse without fall");

  c_read: cover property (reg_rd_en && hit ##1 reg_rd_hit);
  c_bus_fall: cover property (fall_latch_set[1]);
  c_ident_fall: cover property (fall_latch_set[4]);
endmodule : phy_fall_event_enable_asserts

`default_nettype wire

// ==== verification/link_model.sv ====
`default_nettype none

module link_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_hit,
  output logic      [5:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd_en
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus; a released address shows a changed value, never a stale one.
  initial begin
    reg_addr  = 6'h3f;
    reg_wdata = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr_en} = {a, d, 1'b1};
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr_en} = {~a, ~d, 1'b0};
  endtask : wr

  // Read data is registered at the taking edge, so it is taken half a cycle later here.
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic h);
    @(negedge core_clk);
    {reg_addr, reg_rd_en} = {a, 1'b1};
    @(negedge core_clk);
    {reg_addr, reg_rd_en} = {~a, 1'b0};
    d = reg_rdata;
    h = reg_rd_hit;
  endtask : rd
endmodule : link_model

`default_nettype wire

// ==== verification/tb_phy_fall_event_enable.sv ====
`default_nettype none

module tb_phy_fall_event_enable;
  timeunit 1ns;
  timeprecision 1ps;
  import fall_event_pkg::*;

  localparam int unsigned SETTLE_CYCLES = 8;
  logic core_clk = 1'b0, reset = 1'b1;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic reg_wr_en, reg_rd_en, reg_rd_hit;
  logic [4:0] st = 5'h00;
  logic ident_pull_resistor_en = 1'b0, plus_line_pull_down_en = 1'b0, minus_line_pull_down_en = 1'b0;
  fall_mask_t fall_latch_set, fall_enable;
  int n_mismatch = 0, total_checks = 0, cycles = 0;
  wire ident_grounded = st[4];
  wire session_end_status = st[3];
  wire session_valid_status = st[2];
  wire bus_power_valid = st[1];
  wire host_disconnect_status = st[0];

  link_model u_link (.*);
  phy_fall_event_enable #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_dut (.*);

  // Clock, and a ceiling that turns a hang into a failed run.
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp, input logic hexp);
    logic [7:0] d;
    logic h;
    u_link.rd(a, d, h);
    chk("reg_rdata", d, exp);
    chk("reg_rd_hit", {7'h0, h}, {7'h0, hexp});
  endtask : rd_chk

  // Raise one status for a cycle, drop it, then look at the pulse cycle.
  task automatic fall(input int b, input fall_mask_t exp);
    @(negedge core_clk) st[b] = 1'b1;
    @(negedge core_clk) st[b] = 1'b0;
    @(negedge core_clk) chk("fall_latch_set", {3'h0, fall_latch_set}, {3'h0, exp});
  endtask : fall

  task automatic t_regs;
    rd_chk(6'h10, 8'h1f, 1'b1);
    rd_chk(6'h11, 8'h1f, 1'b1);
    rd_chk(6'h12, 8'h1f, 1'b1);
    u_link.wr(6'h10, 8'hea);
    rd_chk(6'h10, 8'h0a, 1'b1);
    u_link.wr(6'h11, 8'h04);
    rd_chk(6'h12, 8'h0e, 1'b1);
    u_link.wr(6'h11, 8'h00);
    rd_chk(6'h10, 8'h0e, 1'b1);
    u_link.wr(6'h10, 8'h1f);
    u_link.wr(6'h12, 8'h04);
    rd_chk(6'h11, 8'h1b, 1'b1);
    u_link.wr(6'h12, 8'h00);
    u_link.wr(6'h13, 8'h00);
    chk("fall_enable", {3'h0, fall_enable}, 8'h1b);
    rd_chk(6'h13, 8'h00, 1'b0);
    u_link.wr(6'h11, 8'h04);
  endtask : t_regs

  task automatic t_falls;
    fall(3, 5'h08);
    fall(2, 5'h04);
    fall(1, 5'h02);
    // Two falls in one cycle set both latch bits, and the pulse lasts one cycle.
    @(negedge core_clk) st[3:2] = 2'b11;
    @(negedge core_clk) st[3:2] = 2'b00;
    @(negedge core_clk) chk("fall_latch_set", {3'h0, fall_latch_set}, 8'h0c);
    @(negedge core_clk) chk("fall_latch_set", {3'h0, fall_latch_set}, 8'h00);
    u_link.wr(6'h12, 8'h02);
    fall(1, 5'h00);
    u_link.wr(6'h11, 8'h02);
    fall(0, 5'h00);
    @(negedge core_clk) {plus_line_pull_down_en, minus_line_pull_down_en} = 2'b11;
    fall(0, 5'h01);
  endtask : t_falls

  task automatic t_ident;
    fall(4, 5'h00);
    @(negedge core_clk) ident_pull_resistor_en = 1'b1;
    fall(4, 5'h00);
    repeat (12) @(negedge core_clk);
    fall(4, 5'h10);
    u_link.wr(6'h12, 8'h10);
    fall(4, 5'h00);
  endtask : t_ident

  // Mid-run reset must bring every enable back on and quiet the pulses.
  task automatic t_reset;
    @(negedge core_clk) reset = 1'b1;
    @(negedge core_clk) chk("fall_latch_set", {3'h0, fall_latch_set}, 8'h00);
    reset = 1'b0;
    chk("fall_enable", {3'h0, fall_enable}, 8'h1f);
    rd_chk(6'h12, 8'h1f, 1'b1);
  endtask : t_reset

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // Main sequence.
  initial begin
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    chk("fall_enable", {3'h0, fall_enable}, 8'h1f);
    t_regs();
    t_falls();
    t_ident();
    t_reset();
    give_verdict();
  end
endmodule : tb_phy_fall_event_enable

bind phy_fall_event_enable phy_fall_event_enable_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.*);

`default_nettype wire
